// ===== rtl/prs_pkg.sv
// Package of constants and carrier types for the power-on reset sequencer.
package prs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int ASSERT_DELAY_NS   = 5000;
    localparam int MIN_ACTIVE_US     = 2000;
    localparam int ASSERT_DELAY_CYC  = (ASSERT_DELAY_NS * 1000) / CLK_PERIOD_PS;
    localparam int MIN_ACTIVE_CYC    = (MIN_ACTIVE_US * 1000000) / CLK_PERIOD_PS;
    localparam int SYNC_STAGES       = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_RESET = 4'h0;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [1:0] SEL_RESET  = 2'h0;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] mirrorBlockAddress;
        logic [1:0] mirrorBlockMode;
        logic [1:0] mirrorBlockSelect;
        logic       mirrorBlockStrobe;
        logic       mirrorOutputEnableN;
    } prs_mirror_ctrl_t;

    typedef enum logic [1:0] {
        PRS_HELD,
        PRS_MIN_HOLD,
        PRS_RUN,
        PRS_PENDING
    } prs_state_t;

endpackage

// ===== rtl/prs_sync.sv
// Multi-stage synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
module prs_sync
    import prs_pkg::*;
#(
    parameter int WIDTH  = 3,
    parameter int STAGES = SYNC_STAGES
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    input  wire logic [WIDTH-1:0] resetValue,
    output logic      [WIDTH-1:0] syncOut
);

    if (STAGES < 2) begin : g_badStages
        $error("prs_sync needs at least two stages");
    end

    logic [WIDTH-1:0] stage [STAGES];

    // The first stage feeds only the second; nothing else samples it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < STAGES; i++) begin
                stage[i] <= '0;
            end
        end else begin
            // Stages hold the input relative to its reset value, which keeps
            // the reset branch constant and the output polarity unchanged.
            stage[0] <= asyncIn ^ resetValue;
            for (int i = 1; i < STAGES; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign syncOut = stage[STAGES-1] ^ resetValue;

endmodule

// ===== rtl/prs_reset_seq.sv
// Reset sequencer and mirror control pin driver.
//
// Behaviour
// - System reset goes low at once when power-on sense falls, stays low.
// - After sense rises, system reset stays low until firmware releases it.
// - System reset asserts about 5 us after power-good or internal reset.
// - Any reset assertion lasts at least 2 ms before release.
// - Controller reset goes low at once when power-on sense falls.
// - After sense rises, controller reset stays low until firmware release.
// - Controller reset on power-good or internal event is selectable.
// - Active-low output enable is driven to the mirror array.
// - Mirror group: 4-bit address, 2-bit mode, 2-bit select, strobe.
// - Secondary controller leaves mirror control outputs unused.
// - Mirror interrupt input is active low with an external pull-up.
`timescale 1ns/1ps
module prs_reset_seq
    import prs_pkg::*;
#(
    parameter int MIN_ACTIVE = MIN_ACTIVE_CYC,
    parameter int DELAY      = ASSERT_DELAY_CYC
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             powerOnSense,
    input  wire logic             supplyGoodIn,
    input  wire logic             mirrorInterruptN,
    input  wire logic             fwRelease,
    input  wire logic             internalReset,
    input  wire logic             ctrlResetOnEvent,
    input  wire logic             secondaryMode,
    input  wire prs_mirror_ctrl_t mirrorCtrlIn,
    output logic                  systemResetOutN,
    output logic                  controllerResetOutN,
    output logic                  mirrorInterrupt,
    output prs_mirror_ctrl_t      mirrorCtrlOut
);

    // A one-cycle delay would drop the reset before it is seen released.
    if (MIN_ACTIVE < 1 || DELAY < 2) begin : g_badCounts
        $error("prs_reset_seq counts are too small");
    end

    localparam int CW = $clog2(MIN_ACTIVE + DELAY + 2);

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [2:0] syncIn;
    logic       senseS;
    logic       goodS;
    logic       intS;

    // Interrupt is inverted so an undriven (pulled-up) pin reads idle.
    prs_sync #(.WIDTH(3), .STAGES(SYNC_STAGES)) u_sync (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .asyncIn    ({powerOnSense, supplyGoodIn, mirrorInterruptN}),
        .resetValue (3'b001),
        .syncOut    (syncIn)
    );

    assign senseS = syncIn[2];
    assign goodS  = syncIn[1];
    assign intS   = ~syncIn[0];

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    logic goodPrev;
    logic goodRise;
    logic evtIn;

    assign goodRise = goodS & ~goodPrev;
    assign evtIn    = goodRise | internalReset;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    prs_state_t     state;
    prs_state_t     next_state;
    logic [CW-1:0]  count;
    logic [CW-1:0]  next_count;
    logic           ctrlHeld;
    logic           next_ctrlHeld;
    logic           minDone;
    logic           delayDone;

    assign minDone   = (count >= CW'(MIN_ACTIVE - 1));
    assign delayDone = (count >= CW'(DELAY - 1));

    always_comb begin
        next_state    = state;
        next_count    = count + CW'(1);
        next_ctrlHeld = ctrlHeld;
        case (state)
            PRS_HELD: begin
                // Sense low holds reset and clears the count; with sense high it runs for min time.
                if (!senseS) begin
                    next_count    = '0;
                    next_ctrlHeld = 1'b1;
                end else if (minDone) begin
                    next_state = PRS_MIN_HOLD;
                end
            end
            PRS_MIN_HOLD: begin
                next_count = count;
                if (!senseS) begin
                    next_state    = PRS_HELD;
                    next_count    = '0;
                    next_ctrlHeld = 1'b1;
                end else if (fwRelease) begin
                    next_state    = PRS_RUN;
                    next_ctrlHeld = 1'b0;
                end
            end
            PRS_RUN: begin
                next_count = '0;
                if (!senseS) begin
                    next_state    = PRS_HELD;
                    next_ctrlHeld = 1'b1;
                end else if (evtIn) begin
                    next_state = PRS_PENDING;
                end
            end
            PRS_PENDING: begin
                if (!senseS) begin
                    next_state    = PRS_HELD;
                    next_count    = '0;
                    next_ctrlHeld = 1'b1;
                end else if (delayDone) begin
                    next_state    = PRS_HELD;
                    next_count    = '0;
                    next_ctrlHeld = ctrlResetOnEvent;
                end
            end
            default: begin
                next_state    = PRS_HELD;
                next_count    = '0;
                next_ctrlHeld = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= PRS_HELD;
            count    <= '0;
            ctrlHeld <= 1'b1;
            goodPrev <= 1'b0;
        end else begin
            state    <= next_state;
            count    <= next_count;
            ctrlHeld <= next_ctrlHeld;
            goodPrev <= goodS;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic sysLow;
    logic ctrlLow;
    prs_mirror_ctrl_t mirrorIdle;

    assign sysLow  = (next_state == PRS_HELD) ||
                     (next_state == PRS_MIN_HOLD);
    assign ctrlLow = sysLow && next_ctrlHeld;
    // Secondary parts park their mirror pins at a fixed idle value.
    assign mirrorIdle = '{mirrorBlockAddress: ADDR_RESET,
                          mirrorBlockMode: MODE_RESET,
                          mirrorBlockSelect: SEL_RESET,
                          mirrorBlockStrobe: 1'b0,
                          mirrorOutputEnableN: 1'b1};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            systemResetOutN     <= 1'b0;
            controllerResetOutN <= 1'b0;
            mirrorInterrupt     <= 1'b0;
            mirrorCtrlOut       <= '{ADDR_RESET, MODE_RESET, SEL_RESET,
                                     1'b0, 1'b1};
        end else begin
            systemResetOutN     <= ~sysLow;
            controllerResetOutN <= ~ctrlLow;
            mirrorInterrupt     <= intS;
            mirrorCtrlOut       <= secondaryMode ? mirrorIdle
                                                 : mirrorCtrlIn;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [CW-1:0] lowCount;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCount <= '0;
        end else if (systemResetOutN) begin
            lowCount <= '0;
        end else if (lowCount != '1) begin
            lowCount <= lowCount + CW'(1);
        end
    end

    AST_SENSE_SYS: assert property (@(posedge core_clk) disable iff (!rst_n)
        !senseS |=> !systemResetOutN)
        else $error("system reset high while sense low");
    AST_SENSE_CTRL: assert property (@(posedge core_clk) disable iff (!rst_n)
        !senseS |=> !controllerResetOutN)
        else $error("controller reset high while sense low");
    AST_FW_SYS: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(systemResetOutN) |-> $past(fwRelease))
        else $error("system reset released without firmware");
    AST_FW_CTRL: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(controllerResetOutN) && state == PRS_RUN
        |-> $past(fwRelease) || $past(state) == PRS_PENDING)
        else $error("controller reset released without firmware");
    AST_MIN_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(systemResetOutN) |-> $past(lowCount) >= CW'(MIN_ACTIVE - 1))
        else $error("reset shorter than minimum");
    AST_EVT_DELAY: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == PRS_RUN && evtIn && senseS && !fwRelease
        |=> systemResetOutN [*2])
        else $error("system reset asserted before delay");
    AST_CTRL_OPT: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == PRS_PENDING && next_state == PRS_HELD && senseS
        && !ctrlResetOnEvent |=> controllerResetOutN)
        else $error("controller reset asserted though not selected");
    AST_SECONDARY: assert property (@(posedge core_clk) disable iff (!rst_n)
        secondaryMode |=> mirrorCtrlOut.mirrorOutputEnableN
        && !mirrorCtrlOut.mirrorBlockStrobe)
        else $error("mirror pins active on secondary");
    AST_MIRROR: assert property (@(posedge core_clk) disable iff (!rst_n)
        !secondaryMode |=> mirrorCtrlOut == $past(mirrorCtrlIn))
        else $error("mirror pins do not follow request");
    AST_INT: assert property (@(posedge core_clk) disable iff (!rst_n)
        !mirrorInterruptN [*4] |-> ##1 mirrorInterrupt)
        else $error("interrupt not reported");

    COV_RELEASE: cover property (@(posedge core_clk) disable iff (!rst_n)
        $rose(systemResetOutN));
    COV_EVENT: cover property (@(posedge core_clk) disable iff (!rst_n)
        state == PRS_PENDING ##1 state == PRS_HELD);
    COV_SENSE_DROP: cover property (@(posedge core_clk) disable iff (!rst_n)
        systemResetOutN ##1 !senseS);

endmodule

// ===== test/prs_monitor_model.sv
// Model of the voltage monitor and of the mirror array interrupt line.
`timescale 1ns/1ps
module prs_monitor_model (
    input  wire logic core_clk,
    output logic      powerOnSense,
    output logic      supplyGoodIn,
    output logic      mirrorInterruptN
);
    logic irqDrive;

    initial begin
        powerOnSense = 1'b0;
        supplyGoodIn = 1'b0;
        irqDrive     = 1'b0;
    end

    // A released line is pulled up, so it reads inactive.
    assign mirrorInterruptN = irqDrive ? 1'b0 : 1'b1;

    // Sense comes first; power-good follows once supplies are in range.
    task automatic powerUp;
        @(posedge core_clk);
        #1 powerOnSense = 1'b1;
        repeat (8) @(posedge core_clk);
        #1 supplyGoodIn = 1'b1;
    endtask

    // Power-good always falls before sense does.
    task automatic powerDown;
        @(posedge core_clk);
        #1 supplyGoodIn = 1'b0;
        repeat (8) @(posedge core_clk);
        #1 powerOnSense = 1'b0;
    endtask

    // A supply dip and recovery with sense kept high.
    task automatic dipGood;
        @(posedge core_clk);
        #1 supplyGoodIn = 1'b0;
        repeat (6) @(posedge core_clk);
        #1 supplyGoodIn = 1'b1;
    endtask

    task automatic irq(input logic on);
        @(posedge core_clk);
        #1 irqDrive = on;
    endtask
endmodule

// ===== test/test_prs_reset_seq.sv
// Self-checking testbench of the reset sequencer.
`timescale 1ns/1ps
module test_prs_reset_seq;
    import prs_pkg::*;
    localparam int MIN_ACT = 20;
    localparam int DLY     = 5;
    logic             core_clk, rst_n, fwRelease, internalReset;
    logic             ctrlResetOnEvent, secondaryMode;
    logic             powerOnSense, supplyGoodIn, mirrorInterruptN;
    logic             systemResetOutN, controllerResetOutN, mirrorInterrupt;
    prs_mirror_ctrl_t mirrorCtrlIn, mirrorCtrlOut;
    int               n_fail  = 0;
    int               n_tests = 0;

    prs_monitor_model mon (.core_clk(core_clk), .powerOnSense(powerOnSense),
        .supplyGoodIn(supplyGoodIn), .mirrorInterruptN(mirrorInterruptN));
    prs_reset_seq #(.MIN_ACTIVE(MIN_ACT), .DELAY(DLY)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .powerOnSense(powerOnSense),
        .supplyGoodIn(supplyGoodIn), .mirrorInterruptN(mirrorInterruptN),
        .fwRelease(fwRelease), .internalReset(internalReset),
        .ctrlResetOnEvent(ctrlResetOnEvent), .secondaryMode(secondaryMode),
        .mirrorCtrlIn(mirrorCtrlIn), .systemResetOutN(systemResetOutN),
        .controllerResetOutN(controllerResetOutN),
        .mirrorInterrupt(mirrorInterrupt), .mirrorCtrlOut(mirrorCtrlOut));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic fail(input string msg);
        n_fail++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic chkBit(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp) fail(m);
    endtask

    task automatic chkPins(input prs_mirror_ctrl_t got,
                           input prs_mirror_ctrl_t exp);
        n_tests++;
        if (got !== exp) fail("mirror pins");
    endtask

    task automatic chkRange(input int got, input int lo, input int hi,
                            input string m);
        n_tests++;
        if (got < lo || got > hi) fail(m);
    endtask

    // Waits for a reset output to reach a level; a bound cuts hangs short.
    task automatic waitRst(input logic ctrl, input logic lvl, output int n);
        n = 0;
        while ((ctrl ? controllerResetOutN : systemResetOutN) !== lvl) begin
            step(1);
            n++;
            if (n > 2000) begin
                fail("wait timed out");
                test_done();
            end
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic scnPowerUp;
        int n;
        chkBit(systemResetOutN, 1'b0, "sys while sense low");
        chkBit(controllerResetOutN, 1'b0, "ctl while sense low");
        mon.powerUp();
        step(MIN_ACT + 10);
        chkBit(systemResetOutN, 1'b0, "sys left early");
        chkBit(controllerResetOutN, 1'b0, "ctl left early");
        fwRelease = 1'b1;
        step(1);
        fwRelease = 1'b0;
        waitRst(1'b0, 1'b1, n);
        chkRange(n, 0, 4, "sys release late");
        chkBit(controllerResetOutN, 1'b1, "ctl not released");
    endtask

    // Release is requested as soon as system reset goes low, so an early exit shows up.
    task automatic scnEvent(input logic ctlOn, input logic internal);
        int n;
        ctrlResetOnEvent = ctlOn;
        if (internal) begin
            internalReset = 1'b1;
            step(1);
            internalReset = 1'b0;
        end else begin
            mon.dipGood();
            #0;
        end
        waitRst(1'b0, 1'b0, n);
        chkRange(n, DLY - 1, DLY + 6, "event delay");
        chkBit(controllerResetOutN, !ctlOn, "ctl on event");
        fwRelease = 1'b1;
        waitRst(1'b0, 1'b1, n);
        fwRelease = 1'b0;
        chkRange(n, MIN_ACT - 1, MIN_ACT + 4, "minimum hold");
        chkBit(controllerResetOutN, 1'b1, "ctl after event");
    endtask

    task automatic scnPowerDown;
        int n;
        mon.powerDown();
        waitRst(1'b0, 1'b0, n);
        chkRange(n, 0, 5, "sys on sense fall");
        chkBit(controllerResetOutN, 1'b0, "ctl on sense fall");
        fwRelease = 1'b1;
        step(40);
        chkBit(systemResetOutN, 1'b0, "sys held");
        chkBit(controllerResetOutN, 1'b0, "ctl held");
        mon.powerUp();
        waitRst(1'b1, 1'b1, n);
        fwRelease = 1'b0;
        chkRange(n, 0, MIN_ACT + 10, "ctl after power-up");
    endtask

    task automatic scnMirror;
        prs_mirror_ctrl_t pat [3] = '{10'h2A5, 10'h35A, 10'h3FE};
        for (int i = 0; i < 3; i++) begin
            mirrorCtrlIn = pat[i];
            step(4);
            chkPins(mirrorCtrlOut, pat[i]);
        end
        secondaryMode = 1'b1;
        step(4);
        chkPins(mirrorCtrlOut, 10'h001);
        secondaryMode = 1'b0;
    endtask

    task automatic scnIrq;
        mon.irq(1'b1);
        step(5);
        chkBit(mirrorInterrupt, 1'b1, "irq seen");
        mon.irq(1'b0);
        step(5);
        chkBit(mirrorInterrupt, 1'b0, "irq idle");
    endtask

    initial begin
        rst_n            = 1'b0;
        fwRelease        = 1'b0;
        internalReset    = 1'b0;
        ctrlResetOnEvent = 1'b0;
        secondaryMode    = 1'b0;
        mirrorCtrlIn     = '0;
        step(10);
        rst_n = 1'b1;
        step(5);
        scnPowerUp();
        scnMirror();
        scnIrq();
        scnEvent(1'b1, 1'b1);
        scnEvent(1'b0, 1'b0);
        scnEvent(1'b1, 1'b0);
        scnEvent(1'b0, 1'b1);
        scnPowerDown();
        test_done();
    end
endmodule
